// ===== dv/tb.sv
`timescale 1ns/100ps
module tb;
    import agc_pkg::*;
    localparam int TICK = 10; // Shortened AGC tick, times scale by 1/100
    logic i_clk, i_rst_b, i_reg_wr, i_reg_rd, i_in_sel, i_lvl_valid;
    logic [REG_AW-1:0] i_reg_addr; // Register address
    logic [15:0] i_reg_wdata; // Write data
    logic signed [7:0] i_lvl; // Measured level, half dB
    logic [15:0] o_reg_rdata; // Read data
    logic o_reg_rvalid, o_in_mute, o_dac_l_mute, o_dac_r_mute;
    logic signed [7:0] o_in_gain; // Amplifier gain
    logic [GAIN_W-1:0] o_dac_l_atten, o_dac_r_atten; // Attenuation codes
    int error_cnt, samples_checked, n;
    logic [15:0] tbl [3]; // Table of write values

    agc_gain_ctrl #(.P_TICK_CYC(TICK)) dut (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .i_in_sel(i_in_sel),
        .i_lvl_valid(i_lvl_valid), .i_lvl(i_lvl), .o_reg_rdata(o_reg_rdata),
        .o_reg_rvalid(o_reg_rvalid), .o_in_mute(o_in_mute),
        .o_in_gain(o_in_gain), .o_dac_l_mute(o_dac_l_mute),
        .o_dac_l_atten(o_dac_l_atten), .o_dac_r_mute(o_dac_r_mute),
        .o_dac_r_atten(o_dac_r_atten));

    ////////////////////////////////////////////////////////////////////////
    // Clock, 100 ns period
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic tick;
        @(posedge i_clk);
        #10;
    endtask

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results;
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // One register write, then two cycles for outputs to follow
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        tick;
        i_reg_wr = 1'b1;
        i_reg_addr = a;
        i_reg_wdata = d;
        tick;
        i_reg_wr = 1'b0;
        tick;
        tick;
    endtask

    // One register read compared with its expected value
    task automatic rd_chk(input logic [6:0] a, input logic [15:0] exp);
        tick;
        i_reg_rd = 1'b1;
        i_reg_addr = a;
        tick;
        check("rvalid", 16'(o_reg_rvalid), 16'h0001);
        check("rdata", o_reg_rdata, exp);
        i_reg_rd = 1'b0;
    endtask

    // DAC outputs packed like the register; input mute packed above the 8-bit gain
    task automatic outs(input logic [15:0] ein, input logic [15:0] edac);
        check("in_outputs", {7'h00, o_in_mute, o_in_gain}, ein);
        check("dac_outputs", {o_dac_l_mute, o_dac_l_atten, o_dac_r_mute,
              o_dac_r_atten}, edac);
    endtask

    // Bounded wait for a given AGC gain; n returns cycles spent
    task automatic wait_gain(input logic [7:0] g, input int lim);
        n = 0;
        while (o_in_gain !== g && n < lim) begin
            tick;
            n++;
        end
        if (o_in_gain !== g) begin
            check("agc_gain", {8'h00, o_in_gain}, {8'h00, g});
            results();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset;
        outs(16'h017f, 16'hffff);
        rd_chk(ADDR_IN_GAIN, IN_GAIN_RST);
        rd_chk(ADDR_DAC_VOL, DAC_VOL_RST);
    endtask

    task automatic t_dac;
        tbl = '{16'h2a55, 16'h80ff, 16'h7f00};
        foreach (tbl[i]) begin
            wr(ADDR_DAC_VOL, tbl[i]);
            outs(16'h017f, tbl[i]);
            rd_chk(ADDR_DAC_VOL, tbl[i]);
        end
        // Unmapped place: write ignored, read gives zero
        wr(7'h03, 16'h0000);
        rd_chk(7'h03, 16'h0000);
        rd_chk(ADDR_DAC_VOL, 16'h7f00);
    endtask

    task automatic t_manual;
        tbl = '{16'h0000, 16'h7f00, 16'hbfe0};
        foreach (tbl[i]) begin
            wr(ADDR_IN_GAIN, tbl[i]);
            outs({7'h00, tbl[i][15], 1'b0, tbl[i][14:8]}, 16'h7f00);
            rd_chk(ADDR_IN_GAIN, tbl[i]);
        end
    endtask

    task automatic t_agc;
        i_lvl = 8'sh00;
        wr(ADDR_IN_GAIN, 16'h9001);
        check("agc_mute", 16'(o_in_mute), 16'h0000);
        wait_gain(8'h0f, 200);
        check("attack_fast", 16'(n < 90), 16'h0001);
        rd_chk(ADDR_IN_GAIN, 16'h0f01);
        wait_gain(8'he8, 5000);
        repeat (200) tick;
        rd_chk(ADDR_IN_GAIN, 16'he801);
        // Level below target: slow rise by one step
        i_lvl = 8'shc4;
        wait_gain(8'he9, 1300);
        check("decay_slow", 16'(n > 800), 16'h0001);
        // Lowest target level (code 7): level now above it, so gain falls
        i_lvl = 8'shd8;
        wr(ADDR_IN_GAIN, 16'h90e1);
        wait_gain(8'he8, 200);
        // Back to first target: level below it, but input deselected
        wr(ADDR_IN_GAIN, 16'h9001);
        i_in_sel = 1'b0;
        repeat (2500) tick;
        check("frozen_gain", {8'h00, o_in_gain}, 16'h00e8);
        rd_chk(ADDR_IN_GAIN, 16'h9001);
        i_in_sel = 1'b1;
        wait_gain(8'he9, 1300);
        // Loud level not flagged valid: ignored, so no attack step
        i_lvl_valid = 1'b0;
        i_lvl = 8'sh00;
        repeat (150) tick;
        check("lvl_ignored", {8'h00, o_in_gain}, 16'h00e9);
        // Longest attack code; level parked on the target first
        i_lvl_valid = 1'b1;
        i_lvl = 8'shd0;
        wr(ADDR_IN_GAIN, 16'h90ff);
        i_lvl = 8'sh00;
        wait_gain(8'he8, 300);
        check("attack_long", 16'(n > 180), 16'h0001);
        wr(ADDR_IN_GAIN, 16'h2000);
        outs(16'h0020, 16'h7f00);
        // Enabling above the read-back range starts from its top
        wr(ADDR_IN_GAIN, 16'h7f01);
        rd_chk(ADDR_IN_GAIN, 16'h7701);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        error_cnt = 0;
        samples_checked = 0;
        i_rst_b = 1'b0;
        i_reg_wr = 1'b0;
        i_reg_rd = 1'b0;
        i_reg_addr = 7'h00;
        i_reg_wdata = 16'h0000;
        i_in_sel = 1'b1;
        i_lvl_valid = 1'b1;
        i_lvl = 8'sh00;
        repeat (3) @(posedge i_clk);
        #10;
        i_rst_b = 1'b1;
        t_reset;
        t_dac;
        t_manual;
        t_agc;
        results();
    end
endmodule

// ===== hw/agc_gain_ctrl.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Input mute bit mutes headset/aux input while AGC off
// - Manual gain 0 to 63.5 dB, half-dB steps
// - AGC on and selected: gain fields read back
// - Read-back gain signed, +59.5 to -12 dB
// - Target field picks AGC output level
// - AGC times fixed, independent of sample rate
// - Code picks decay group and attack time
// - Enable bit hands amplifier gain to AGC
// - Left mute bit mutes left DAC
// - Left volume attenuates 0 to -63.5 dB
// - Right mute bit mutes right DAC
// - Right volume attenuates independently, same range
module agc_gain_ctrl #(
    parameter int P_TICK_CYC = agc_pkg::TICK_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [agc_pkg::REG_AW-1:0] i_reg_addr,
    input wire logic [15:0] i_reg_wdata,
    input wire logic i_in_sel,
    input wire logic i_lvl_valid,
    input wire logic signed [7:0] i_lvl,
    output logic [15:0] o_reg_rdata,
    output logic o_reg_rvalid,
    output logic o_in_mute,
    output logic signed [7:0] o_in_gain,
    output logic o_dac_l_mute,
    output logic [agc_pkg::GAIN_W-1:0] o_dac_l_atten,
    output logic o_dac_r_mute,
    output logic [agc_pkg::GAIN_W-1:0] o_dac_r_atten
);
    import agc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [15:0] in_reg_r;                 // Input gain / AGC register
    logic [15:0] dac_reg_r;                // DAC volume register
    logic signed [7:0] agc_gain_r;         // Gain applied by AGC
    logic signed [7:0] lvl_r;              // Last measured output level
    logic [15:0] tick_cnt_r;               // Tick divider
    logic tick_r;                          // One-cycle tick enable
    logic [STEP_W-1:0] step_cnt_r;         // Ticks since last step
    agc_mode_e mode_r;                     // AGC mode
    agc_mode_e mode_nxt;
    logic agc_en;                          // Enable bit
    logic signed [7:0] target;             // Selected target level
    logic above;                           // Level over target
    logic below;                           // Level under target
    logic [STEP_W-1:0] interval;           // Current step interval
    logic agc_step;                        // Gain step this cycle
    logic [15:0] in_rd;                    // Input register read view

    assign agc_en = in_reg_r[AGC_EN_BIT];
    assign target = agc_target(in_reg_r[TGT_LSB +: TGT_W]);
    assign above = lvl_r > target;
    assign below = lvl_r < target;
    // Attack when too loud, decay when too quiet
    assign interval = above ?
        agc_ticks(agc_attack_ms(in_reg_r[TC_LSB +: 2])) :
        agc_ticks(agc_decay_ms(in_reg_r[TC_LSB + 2 +: 2]));
    assign agc_step = (mode_r == AGC_RUN) && tick_r && (above || below)
        && (step_cnt_r >= interval - 14'h1);

    ////////////////////////////////////////////////////////////////////////
    // Register writes
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            in_reg_r <= IN_GAIN_RST;
            dac_reg_r <= DAC_VOL_RST;
        end else if (i_reg_wr) begin
            // Writes always land in the programmed fields
            if (i_reg_addr == ADDR_IN_GAIN) begin
                in_reg_r <= i_reg_wdata;
            end
            if (i_reg_addr == ADDR_DAC_VOL) begin
                dac_reg_r <= i_reg_wdata;
            end
        end
    end

    // Read view: AGC gain replaces mute and gain fields when tracking
    always_comb begin
        in_rd = in_reg_r;
        if (agc_en && i_in_sel) begin
            in_rd[15:8] = agc_gain_r;
        end
    end

    // Read data, registered, unmapped reads give zero
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_reg_rdata <= 16'h0000;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (!i_reg_rd) begin
                o_reg_rdata <= 16'h0000;
            end else if (i_reg_addr == ADDR_IN_GAIN) begin
                o_reg_rdata <= in_rd;
            end else if (i_reg_addr == ADDR_DAC_VOL) begin
                o_reg_rdata <= dac_reg_r;
            end else begin
                o_reg_rdata <= 16'h0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Tick divider on the system clock only, not the sample clock
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tick_cnt_r <= 16'h0000;
            tick_r <= 1'b0;
        end else if (tick_cnt_r >= 16'(P_TICK_CYC - 1)) begin
            tick_cnt_r <= 16'h0000;
            tick_r <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 16'h0001;
            tick_r <= 1'b0;
        end
    end

    // Mode: off, holding while input not selected, running
    always_comb begin
        if (!agc_en) begin
            mode_nxt = AGC_OFF;
        end else if (!i_in_sel) begin
            mode_nxt = AGC_HOLD;
        end else begin
            mode_nxt = AGC_RUN;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mode_r <= AGC_OFF;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // Latch the measured output level
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            lvl_r <= 8'sh00;
        end else if (i_lvl_valid) begin
            lvl_r <= i_lvl;
        end
    end

    // Ticks since last step; restarts on step or when idle
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            step_cnt_r <= '0;
        end else if (mode_r != AGC_RUN || agc_step || !(above || below)) begin
            step_cnt_r <= '0;
        end else if (tick_r && step_cnt_r != '1) begin
            step_cnt_r <= step_cnt_r + 14'h1;
        end
    end

    // AGC gain: tracks manual gain while off, steps while running
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            agc_gain_r <= 8'sh00;
        end else if (mode_r == AGC_OFF) begin
            // Start from manual gain, held inside the read-back range
            if (in_reg_r[IN_GAIN_LSB +: GAIN_W] > AGC_GAIN_MAX[6:0]) begin
                agc_gain_r <= AGC_GAIN_MAX;
            end else begin
                agc_gain_r <= {1'b0, in_reg_r[IN_GAIN_LSB +: GAIN_W]};
            end
        end else if (agc_step && above && agc_gain_r > AGC_GAIN_MIN) begin
            agc_gain_r <= agc_gain_r - 8'sh01;
        end else if (agc_step && below && agc_gain_r < AGC_GAIN_MAX) begin
            agc_gain_r <= agc_gain_r + 8'sh01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input amplifier controls
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_in_mute <= 1'b1;
            o_in_gain <= 8'sh7f;
        end else if (agc_en) begin
            o_in_mute <= 1'b0;
            o_in_gain <= agc_gain_r;
        end else begin
            o_in_mute <= in_reg_r[IN_MUTE_BIT];
            o_in_gain <= {1'b0, in_reg_r[IN_GAIN_LSB +: GAIN_W]};
        end
    end

    // DAC channel controls
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_dac_l_mute <= 1'b1;
            o_dac_l_atten <= 7'h7f;
            o_dac_r_mute <= 1'b1;
            o_dac_r_atten <= 7'h7f;
        end else begin
            o_dac_l_mute <= dac_reg_r[L_MUTE_BIT];
            o_dac_l_atten <= dac_reg_r[L_VOL_LSB +: GAIN_W];
            o_dac_r_mute <= dac_reg_r[R_MUTE_BIT];
            o_dac_r_atten <= dac_reg_r[R_VOL_LSB +: GAIN_W];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    sequence s_manual;
        !agc_en;
    endsequence
    sequence s_step_dn;
        agc_step && above && agc_gain_r > AGC_GAIN_MIN && mode_r == AGC_RUN;
    endsequence

    property p_in_mute;
        s_manual |=> o_in_mute == $past(in_reg_r[IN_MUTE_BIT]);
    endproperty
    a_in_mute: assert property (p_in_mute)
        else $error("input mute not following register");

    property p_in_gain;
        s_manual |=> o_in_gain == {1'b0, $past(in_reg_r[14:8])};
    endproperty
    a_in_gain: assert property (p_in_gain)
        else $error("manual input gain wrong");

    property p_readback;
        i_reg_rd && i_reg_addr == ADDR_IN_GAIN && agc_en && i_in_sel
            |=> o_reg_rvalid && o_reg_rdata[15:8] == $past(agc_gain_r);
    endproperty
    a_readback: assert property (p_readback)
        else $error("AGC gain not read back");

    property p_range;
        mode_r != AGC_OFF |-> agc_gain_r >= AGC_GAIN_MIN
            && agc_gain_r <= AGC_GAIN_MAX;
    endproperty
    a_range: assert property (p_range)
        else $error("AGC gain out of range");

    property p_attack;
        s_step_dn |=> agc_gain_r == $past(agc_gain_r) - 8'sh01;
    endproperty
    a_attack: assert property (p_attack)
        else $error("AGC did not step down when above target");

    property p_spacing;
        agc_step |=> !agc_step [*8];
    endproperty
    a_spacing: assert property (p_spacing)
        else $error("AGC steps too close");

    property p_agc_drive;
        agc_en ##1 agc_en |-> !o_in_mute && o_in_gain == $past(agc_gain_r);
    endproperty
    a_agc_drive: assert property (p_agc_drive)
        else $error("amplifier not driven by AGC");

    property p_dac_l;
        ##1 1 |-> o_dac_l_mute == $past(dac_reg_r[15])
            && o_dac_l_atten == $past(dac_reg_r[14:8]);
    endproperty
    a_dac_l: assert property (p_dac_l)
        else $error("left DAC controls wrong");

    property p_dac_r;
        ##1 1 |-> o_dac_r_mute == $past(dac_reg_r[7])
            && o_dac_r_atten == $past(dac_reg_r[6:0]);
    endproperty
    a_dac_r: assert property (p_dac_r)
        else $error("right DAC controls wrong");

    property p_hold;
        mode_r == AGC_HOLD |=> agc_gain_r == $past(agc_gain_r);
    endproperty
    a_hold: assert property (p_hold)
        else $error("AGC gain moved while input not selected");

endmodule

// ===== shared/agc_pkg.sv
package agc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register map and field layout
    localparam int REG_AW = 7;                          // Register address width
    localparam logic [6:0] ADDR_IN_GAIN = 7'h01;        // Input gain / AGC control
    localparam logic [6:0] ADDR_DAC_VOL = 7'h02;        // DAC volume control
    localparam int IN_MUTE_BIT = 15;                    // Input mute
    localparam int IN_GAIN_LSB = 8;                     // Input gain field low bit
    localparam int GAIN_W = 7;                          // Gain / volume field width
    localparam int TGT_LSB = 5;                         // AGC target field low bit
    localparam int TGT_W = 3;                           // AGC target field width
    localparam int TC_LSB = 1;                          // AGC time constant low bit
    localparam int TC_W = 4;                            // AGC time constant width
    localparam int AGC_EN_BIT = 0;                      // AGC enable
    localparam int L_MUTE_BIT = 15;                     // Left DAC mute
    localparam int L_VOL_LSB = 8;                       // Left DAC volume low bit
    localparam int R_MUTE_BIT = 7;                      // Right DAC mute
    localparam int R_VOL_LSB = 0;                       // Right DAC volume low bit
    localparam logic [15:0] IN_GAIN_RST = 16'hff00;     // Muted, max gain, AGC off
    localparam logic [15:0] DAC_VOL_RST = 16'hffff;     // Both muted, full atten

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_NS = 100;                        // 10 MHz clock period
    localparam int TICK_NS = 100000;                    // AGC step tick, 100 us
    localparam int TICK_CYC = TICK_NS / CLK_NS;         // Cycles per tick
    localparam int MS_NS = 1000000;                     // One millisecond
    localparam int TICKS_PER_MS = MS_NS / TICK_NS;      // Ticks per millisecond
    localparam int STEP_W = 14;                         // Step interval counter

    ////////////////////////////////////////////////////////////////////////
    // AGC gain range, signed half-dB units
    localparam logic signed [7:0] AGC_GAIN_MAX = 8'sh77; // +59.5 dB
    localparam logic signed [7:0] AGC_GAIN_MIN = 8'she8; // -12 dB

    // AGC operating mode
    typedef enum logic [1:0] {AGC_OFF, AGC_HOLD, AGC_RUN} agc_mode_e;

    // Target output level in signed half-dB
    function automatic logic signed [7:0] agc_target(input logic [2:0] code);
        unique case (code)
            3'h0: agc_target = 8'shf5;
            3'h1: agc_target = 8'shf0;
            3'h2: agc_target = 8'shec;
            3'h3: agc_target = 8'she8;
            3'h4: agc_target = 8'she4;
            3'h5: agc_target = 8'shde;
            3'h6: agc_target = 8'shd8;
            3'h7: agc_target = 8'shd0;
        endcase
    endfunction

    // Attack time in ms from the low two code bits
    function automatic logic [8:0] agc_attack_ms(input logic [1:0] code);
        unique case (code)
            2'h0: agc_attack_ms = 9'h008;
            2'h1: agc_attack_ms = 9'h00b;
            2'h2: agc_attack_ms = 9'h010;
            2'h3: agc_attack_ms = 9'h014;
        endcase
    endfunction

    // Decay time in ms from the high two code bits
    function automatic logic [8:0] agc_decay_ms(input logic [1:0] code);
        unique case (code)
            2'h0: agc_decay_ms = 9'h064;
            2'h1: agc_decay_ms = 9'h0c8;
            2'h2: agc_decay_ms = 9'h190;
            2'h3: agc_decay_ms = 9'h1f4;
        endcase
    endfunction

    // Step interval in ticks: one step per tenth of the time constant
    function automatic logic [13:0] agc_ticks(input logic [8:0] ms);
        agc_ticks = 14'(int'(ms) * TICKS_PER_MS / 10);
    endfunction

endpackage
